/* File: core/dcd_decoder.sv */
// Discrete command decoder with Avalon-MM register access.
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dcd_decoder #(
  parameter logic CONC_OPT = 1'b1,
  parameter logic DIAG_OPT = 1'b1
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output var dcd_pkg::dcd_pulse_s pulse_out,
  output var dcd_pkg::dcd_state_s state_out
);
  logic [7:0] cmd_q;
  logic [7:0] prev_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic pzr_q;
  logic warn_q;
  logic [1:0] spec_q;
  dcd_pkg::dcd_acq_e acq_q;
  dcd_pkg::dcd_pulse_s pulse_q;
  dcd_pkg::dcd_pulse_s pulse_d;
  dcd_pkg::dcd_pulse_s pulse_seen_q;
  logic [7:0] last_cmd_q;

  // With the enable high, every access takes exactly one wait cycle, so the answer comes on the second edge.
  wire access = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = access & ~ack_q;
  wire take = access & ack_q & ce_in;
  wire cmd_wr = take & avs_write_in & (avs_address_in == dcd_pkg::REG_CMD) & avs_byteenable_in[0];
  wire [7:0] cmd_d = cmd_wr ? avs_writedata_in[7:0] : cmd_q;

  // A command fires only on the first enabled cycle after the value leaves state 0.
  wire fire = (prev_q == dcd_pkg::CMD_IDLE) && (cmd_q != dcd_pkg::CMD_IDLE);
  wire is_diag_code = (cmd_q == dcd_pkg::CMD_WARN_OFF) || (cmd_q == dcd_pkg::CMD_WARN_ON) ||
    ((cmd_q >= dcd_pkg::CMD_REF_DET) && (cmd_q <= dcd_pkg::CMD_DIAG_DET));
  wire diag_ok = fire & is_diag_code & DIAG_OPT;
  wire base_ok = fire & ~is_diag_code;
  wire is_spec = (cmd_q >= dcd_pkg::CMD_SPEC1) && (cmd_q <= dcd_pkg::CMD_SPEC4);
  wire [7:0] spec_off = cmd_q - dcd_pkg::CMD_SPEC1;

  always_comb begin
    pulse_d = '0;
    // Reserved codes fall through every decode below and raise no pulse; last_cmd_q still records them.
    pulse_d.tot1_clr = base_ok & ((cmd_q == dcd_pkg::CMD_TOT_ALL) | (cmd_q == dcd_pkg::CMD_TOT1));
    pulse_d.tot2_clr = base_ok & ((cmd_q == dcd_pkg::CMD_TOT_ALL) | (cmd_q == dcd_pkg::CMD_TOT2));
    pulse_d.tot3_clr = base_ok & ((cmd_q == dcd_pkg::CMD_TOT_ALL) | (cmd_q == dcd_pkg::CMD_TOT3));
    pulse_d.ref_start = diag_ok & (cmd_q == dcd_pkg::CMD_REF_DET);
    pulse_d.hist_clr = diag_ok & (cmd_q == dcd_pkg::CMD_HIST_CLR);
    pulse_d.diag_start = diag_ok & (cmd_q == dcd_pkg::CMD_DIAG_DET);
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cmd_q <= dcd_pkg::CMD_IDLE;
      prev_q <= dcd_pkg::CMD_IDLE;
      ack_q <= 1'b0;
      pulse_q <= '0;
    end else if (ce_in) begin
      cmd_q <= cmd_d;
      prev_q <= cmd_q;
      ack_q <= access & ~ack_q;
      pulse_q <= pulse_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pzr_q <= 1'b0;
      warn_q <= 1'b0;
      spec_q <= 2'h0;
      acq_q <= dcd_pkg::DCD_ACQ_OFF;
    end else if (ce_in && fire) begin
      if (base_ok && cmd_q == dcd_pkg::CMD_PZR_ON) begin
        pzr_q <= 1'b1;
      end
      if (base_ok && cmd_q == dcd_pkg::CMD_PZR_OFF) begin
        pzr_q <= 1'b0;
      end
      if (base_ok && is_spec && CONC_OPT) begin
        spec_q <= spec_off[1:0];
      end
      if (diag_ok && cmd_q == dcd_pkg::CMD_WARN_OFF) begin
        warn_q <= 1'b0;
      end
      if (diag_ok && cmd_q == dcd_pkg::CMD_WARN_ON) begin
        warn_q <= 1'b1;
      end
      if (diag_ok && cmd_q == dcd_pkg::CMD_ACQ_OFF) begin
        acq_q <= dcd_pkg::DCD_ACQ_OFF;
      end
      if (diag_ok && cmd_q == dcd_pkg::CMD_ACQ_PER) begin
        acq_q <= dcd_pkg::DCD_ACQ_PERIODIC;
      end
      if (diag_ok && cmd_q == dcd_pkg::CMD_ACQ_MAN) begin
        acq_q <= dcd_pkg::DCD_ACQ_MANUAL;
      end
    end
  end

  // Sticky record of pulses and the last accepted code; a new event wins over the read clear.
  wire pulse_rd = take & avs_read_in & (avs_address_in == dcd_pkg::REG_PULSE);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pulse_seen_q <= '0;
      last_cmd_q <= dcd_pkg::CMD_IDLE;
    end else if (ce_in) begin
      pulse_seen_q <= (pulse_rd ? '0 : pulse_seen_q) | pulse_q;
      if (fire) begin
        last_cmd_q <= cmd_q;
      end
    end
  end

  wire [31:0] rd_cmd = {24'h000000, cmd_q};
  wire [31:0] rd_status = {16'h0000, last_cmd_q, 2'h0, acq_q, spec_q, warn_q, pzr_q};
  wire [31:0] rd_pulse = {26'h0000000, pulse_seen_q};
  wire [31:0] rd_config = {24'h000000, dcd_pkg::DCD_CHANNEL[5:0], DIAG_OPT, CONC_OPT};
  wire [31:0] rd_mux = (avs_address_in == dcd_pkg::REG_CMD) ? rd_cmd :
    (avs_address_in == dcd_pkg::REG_STATUS) ? rd_status :
    (avs_address_in == dcd_pkg::REG_PULSE) ? rd_pulse : rd_config;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rdata_q <= 32'h00000000;
    end else if (ce_in && avs_read_in && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata_out = rdata_q;
  assign pulse_out = pulse_q;
  assign state_out = '{pzr_on: pzr_q, warn_on: warn_q, spec_sel: spec_q, acq_mode: acq_q};

  a_pulse_once: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && pulse_q != '0) |=> (pulse_q == '0))
    else $error("command pulse lasted more than one cycle");
  a_tot_all: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && cmd_q == dcd_pkg::CMD_TOT_ALL) |=> (pulse_q.tot1_clr && pulse_q.tot2_clr && pulse_q.tot3_clr))
    else $error("total reset did not clear all totalizers");
  a_tot_one: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && cmd_q == dcd_pkg::CMD_TOT1) |=> (pulse_q.tot1_clr && !pulse_q.tot2_clr && !pulse_q.tot3_clr))
    else $error("single reset touched other totalizers");
  a_pzr_on: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && cmd_q == dcd_pkg::CMD_PZR_ON) |=> state_out.pzr_on)
    else $error("zero return not switched on");
  a_pzr_off: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && cmd_q == dcd_pkg::CMD_PZR_OFF) |=> !state_out.pzr_on)
    else $error("zero return not switched off");
  a_reserved_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && (cmd_q == dcd_pkg::CMD_RSV1 || cmd_q == dcd_pkg::CMD_RSV5 || cmd_q == dcd_pkg::CMD_RSV6 ||
    (cmd_q >= dcd_pkg::CMD_RSV71 && cmd_q <= dcd_pkg::CMD_RSV73))) |=> (pulse_q == '0 && $stable(state_out)))
    else $error("reserved code caused an action");
  a_spec_sel: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && CONC_OPT && cmd_q == dcd_pkg::CMD_SPEC4) |=> (state_out.spec_sel == 2'h3))
    else $error("specification 4 not selected");
  a_warn_mode: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && diag_ok && cmd_q == dcd_pkg::CMD_WARN_ON) |=> state_out.warn_on)
    else $error("warning mode not switched on");
  a_acq_mode: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && diag_ok && cmd_q == dcd_pkg::CMD_ACQ_PER) |=> (state_out.acq_mode == dcd_pkg::DCD_ACQ_PERIODIC))
    else $error("acquisition mode not periodic");
  a_ref_start: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && diag_ok && cmd_q == dcd_pkg::CMD_REF_DET) |=> pulse_q.ref_start)
    else $error("reference determination not started");
  a_hist_clr: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && diag_ok && cmd_q == dcd_pkg::CMD_HIST_CLR) |=> pulse_q.hist_clr)
    else $error("history not cleared");
  a_diag_start: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && diag_ok && cmd_q == dcd_pkg::CMD_DIAG_DET) |=> pulse_q.diag_start)
    else $error("manual determination not started");
  a_diag_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (!DIAG_OPT && ce_in) |=> (!pulse_q.ref_start && !pulse_q.hist_clr && !pulse_q.diag_start))
    else $error("diagnostic code acted without option");

  // Handshake steps: a request is first held off for one enabled edge, then taken on the next.
  sequence s_req_held;
    ce_in && access && !ack_q;
  endsequence

  sequence s_req_taken;
    ce_in && access && ack_q;
  endsequence

  // A command fires on the first enabled cycle after the code leaves state 0.
  sequence s_fires(logic [7:0] code);
    ce_in && fire && cmd_q == code;
  endsequence

  // Diagnostic commands fire only where the option lets them through.
  sequence s_diag_fires(logic [7:0] code);
    ce_in && diag_ok && cmd_q == code;
  endsequence

  a_wait_first: assert property (@(posedge clk_in) disable iff (srst_in)
    s_req_held |->
    avs_waitrequest_out)
    else $error("request not held off for its wait cycle");

  a_wait_one: assert property (@(posedge clk_in) disable iff (srst_in)
    (s_req_held ##1 access) |->
    !avs_waitrequest_out)
    else $error("wait cycle lasted more than one cycle");

  a_ack_drop: assert property (@(posedge clk_in) disable iff (srst_in)
    s_req_taken |=>
    !ack_q)
    else $error("acknowledge stood for two cycles");

  a_ack_idle: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && !access) |=>
    !ack_q)
    else $error("acknowledge without a request");

  a_cmd_write: assert property (@(posedge clk_in) disable iff (srst_in)
    (s_req_taken ##0 (avs_write_in && avs_address_in == dcd_pkg::REG_CMD && avs_byteenable_in[0])) |=>
    (cmd_q == $past(avs_writedata_in[7:0])))
    else $error("command write did not land");

  a_cmd_masked: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && !cmd_wr) |=>
    $stable(cmd_q))
    else $error("command changed without a write");

  a_read_data: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && avs_read_in && !ack_q) |=>
    (avs_readdata_out == $past(rd_mux)))
    else $error("read data not captured");

  a_rdata_hold: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && !(avs_read_in && !ack_q)) |=>
    $stable(avs_readdata_out))
    else $error("read data changed without a read");

  // A low enable must freeze every piece of state, including the handshake.
  a_freeze_all: assert property (@(posedge clk_in) disable iff (srst_in)
    !ce_in |=>
    ($stable(cmd_q) && $stable(pulse_q) && $stable(state_out) && $stable(ack_q)))
    else $error("state moved while the enable was low");

  a_no_refire: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && prev_q != dcd_pkg::CMD_IDLE) |=>
    (pulse_q == '0))
    else $error("command fired without a change from state 0");

  a_state_quiet: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && !fire) |=>
    $stable(state_out))
    else $error("state changed without a command");

  a_last_code: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire) |=>
    (last_cmd_q == $past(cmd_q)))
    else $error("accepted code not recorded");

  a_tot_two: assert property (@(posedge clk_in) disable iff (srst_in)
    s_fires(dcd_pkg::CMD_TOT2) |=>
    (!pulse_q.tot1_clr && pulse_q.tot2_clr && !pulse_q.tot3_clr))
    else $error("totalizer 2 reset wrong");

  a_tot_three: assert property (@(posedge clk_in) disable iff (srst_in)
    s_fires(dcd_pkg::CMD_TOT3) |=>
    (!pulse_q.tot1_clr && !pulse_q.tot2_clr && pulse_q.tot3_clr))
    else $error("totalizer 3 reset wrong");

  a_tot_source: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && !base_ok) |=>
    (!pulse_q.tot1_clr && !pulse_q.tot2_clr && !pulse_q.tot3_clr))
    else $error("totalizer reset without its command");

  a_pzr_keep: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && cmd_q != dcd_pkg::CMD_PZR_ON && cmd_q != dcd_pkg::CMD_PZR_OFF) |=>
    $stable(state_out.pzr_on))
    else $error("zero return moved by another code");

  a_spec_one: assert property (@(posedge clk_in) disable iff (srst_in)
    (s_fires(dcd_pkg::CMD_SPEC1) ##0 CONC_OPT) |=>
    (state_out.spec_sel == 2'h0))
    else $error("specification 1 not selected");

  a_spec_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && !CONC_OPT) |=>
    $stable(state_out.spec_sel))
    else $error("specification changed without option");

  a_warn_off: assert property (@(posedge clk_in) disable iff (srst_in)
    s_diag_fires(dcd_pkg::CMD_WARN_OFF) |=>
    !state_out.warn_on)
    else $error("warning mode not switched off");

  a_acq_off: assert property (@(posedge clk_in) disable iff (srst_in)
    s_diag_fires(dcd_pkg::CMD_ACQ_OFF) |=>
    (state_out.acq_mode == dcd_pkg::DCD_ACQ_OFF))
    else $error("acquisition mode not off");

  a_acq_manual: assert property (@(posedge clk_in) disable iff (srst_in)
    s_diag_fires(dcd_pkg::CMD_ACQ_MAN) |=>
    (state_out.acq_mode == dcd_pkg::DCD_ACQ_MANUAL))
    else $error("acquisition mode not manual");

  a_diag_state: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && fire && is_diag_code && !DIAG_OPT) |=>
    ($stable(state_out.warn_on) && $stable(state_out.acq_mode)))
    else $error("diagnostic state changed without option");

  a_diag_source: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && !diag_ok) |=>
    (!pulse_q.ref_start && !pulse_q.hist_clr && !pulse_q.diag_start))
    else $error("diagnostic pulse without its command");

  // The sticky record must never lose a pulse, even when a read clears it in the same cycle.
  a_sticky_set: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && pulse_q != '0) |=>
    ((pulse_seen_q & $past(pulse_q)) == $past(pulse_q)))
    else $error("pulse missing from the sticky record");

  a_sticky_clear: assert property (@(posedge clk_in) disable iff (srst_in)
    (ce_in && pulse_rd && pulse_q == '0) |=>
    (pulse_seen_q == '0))
    else $error("sticky record not cleared by its read");
endmodule
`default_nettype wire

/* File: core/dcd_pkg.sv */
// Package with command codes, register map and types of the discrete command decoder.
package dcd_pkg;
  localparam int DCD_CMD_W = 8;
  localparam logic [7:0] DCD_CHANNEL = 8'h10;
  localparam logic [7:0] CMD_IDLE = 8'h00;
  localparam logic [7:0] CMD_RSV1 = 8'h01;
  localparam logic [7:0] CMD_PZR_ON = 8'h02;
  localparam logic [7:0] CMD_PZR_OFF = 8'h03;
  localparam logic [7:0] CMD_RSV5 = 8'h05;
  localparam logic [7:0] CMD_RSV6 = 8'h06;
  localparam logic [7:0] CMD_TOT_ALL = 8'h07;
  localparam logic [7:0] CMD_TOT1 = 8'h08;
  localparam logic [7:0] CMD_TOT2 = 8'h09;
  localparam logic [7:0] CMD_TOT3 = 8'h0A;
  localparam logic [7:0] CMD_WARN_OFF = 8'h19;
  localparam logic [7:0] CMD_WARN_ON = 8'h1A;
  localparam logic [7:0] CMD_SPEC1 = 8'h3C;
  localparam logic [7:0] CMD_SPEC4 = 8'h3F;
  localparam logic [7:0] CMD_REF_DET = 8'h46;
  localparam logic [7:0] CMD_RSV71 = 8'h47;
  localparam logic [7:0] CMD_RSV73 = 8'h49;
  localparam logic [7:0] CMD_ACQ_OFF = 8'h4A;
  localparam logic [7:0] CMD_ACQ_PER = 8'h4B;
  localparam logic [7:0] CMD_ACQ_MAN = 8'h4C;
  localparam logic [7:0] CMD_HIST_CLR = 8'h4D;
  localparam logic [7:0] CMD_DIAG_DET = 8'h4E;

  // Register word addresses (byte address / 4).
  localparam logic [1:0] REG_CMD = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_PULSE = 2'h2;
  localparam logic [1:0] REG_CONFIG = 2'h3;

  typedef enum logic [1:0] {
    DCD_ACQ_OFF = 2'b00,
    DCD_ACQ_PERIODIC = 2'b01,
    DCD_ACQ_MANUAL = 2'b10
  } dcd_acq_e;

  typedef struct packed {
    logic tot1_clr;
    logic tot2_clr;
    logic tot3_clr;
    logic ref_start;
    logic hist_clr;
    logic diag_start;
  } dcd_pulse_s;

  typedef struct packed {
    logic pzr_on;
    logic warn_on;
    logic [1:0] spec_sel;
    dcd_acq_e acq_mode;
  } dcd_state_s;
endpackage

/* File: tb/dcd_host_model.sv */
// Host model that issues register accesses to the decoder over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module dcd_host_model (
  input wire logic clk_in,
  input wire logic waitrequest_in,
  input wire logic [31:0] readdata_in,
  output logic [1:0] address_out,
  output logic read_out,
  output logic write_out,
  output logic [31:0] writedata_out,
  output logic [3:0] byteenable_out
);
  initial begin
    address_out = 2'h0;
    read_out = 1'b0;
    write_out = 1'b0;
    writedata_out = 32'h00000000;
    byteenable_out = 4'hF;
  end

  // The request stands until waitrequest is seen low at a rising edge; the bound stops a hung slave.
  task automatic access(input logic rd, input logic [1:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    begin
      @(posedge clk_in);
      address_out <= a;
      writedata_out <= d;
      read_out <= rd;
      write_out <= !rd;
      n = 0;
      do begin
        @(posedge clk_in);
        n++;
      end while (waitrequest_in !== 1'b0 && n < 50);
      q = readdata_in;
      read_out <= 1'b0;
      write_out <= 1'b0;
      if (waitrequest_in !== 1'b0) begin
        tb_top.failures++;
        tb_top.stop_test();
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the discrete command decoder.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
  logic clk_in;
  logic srst_in;
  logic ce_in;
  logic [1:0] adr;
  logic rd;
  logic wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wait_req;
  dcd_pkg::dcd_pulse_s pulse;
  dcd_pkg::dcd_state_s state;
  dcd_pkg::dcd_state_s state_nopt;
  logic [31:0] q;
  int failures = 0;
  int cmp_count = 0;
  // Each entry holds the code, the expected status byte and the expected sticky pulse byte.
  logic [23:0] tbl [0:24] = '{24'h020100, 24'h070138, 24'h080120, 24'h090110, 24'h0A0108, 24'h3D0500,
    24'h3F0D00, 24'h1A0F00, 24'h190D00, 24'h460D04, 24'h4B1D00, 24'h4C2D00, 24'h4A0D00, 24'h4D0D02,
    24'h4E0D01, 24'h030C00, 24'h010C00, 24'h050C00, 24'h060C00, 24'h470C00, 24'h480C00, 24'h490C00,
    24'h3C0000, 24'h040000, 24'h1B0000};

  dcd_decoder dcd_decoder_inst (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wait_req), .pulse_out(pulse), .state_out(state));
  // A second decoder without options shares the bus inputs so option gating is seen on the same traffic.
  dcd_decoder #(.CONC_OPT(1'b0), .DIAG_OPT(1'b0)) dcd_decoder_nopt_inst (.clk_in(clk_in), .srst_in(srst_in),
    .ce_in(ce_in), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(), .avs_waitrequest_out(), .pulse_out(), .state_out(state_nopt));
  dcd_host_model host (.clk_in(clk_in), .waitrequest_in(wait_req), .readdata_in(rdata), .address_out(adr),
    .read_out(rd), .write_out(wr), .writedata_out(wdata), .byteenable_out(be));

  task automatic stop_test();
    begin
      $display("Counts: %0d compares, %0d failures", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  initial begin
    srst_in = 1'b1;
    ce_in = 1'b1;
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    host.access(1'b1, dcd_pkg::REG_CONFIG, 32'h00000000, q);
    `CHK("config", 32'h00000043, q)
    host.access(1'b0, dcd_pkg::REG_STATUS, 32'hFFFFFFFF, q);
    host.access(1'b1, dcd_pkg::REG_STATUS, 32'h00000000, q);
    `CHK("status_ro", 32'h00000000, q)
    $display("test reset done");
    for (int i = 0; i < 25; i++) begin
      host.access(1'b0, dcd_pkg::REG_CMD, {24'h000000, tbl[i][23:16]}, q);
      host.access(1'b0, dcd_pkg::REG_CMD, 32'h00000000, q);
      host.access(1'b1, dcd_pkg::REG_STATUS, 32'h00000000, q);
      `CHK("status", {16'h0000, tbl[i][23:8]}, q)
      host.access(1'b1, dcd_pkg::REG_PULSE, 32'h00000000, q);
      `CHK("pulse", {26'h0000000, tbl[i][5:0]}, q)
      `CHK("state", {tbl[i][8], tbl[i][9], tbl[i][11:10], tbl[i][13:12]}, state)
      `CHK("state_nopt", {tbl[i][8], 5'h00}, state_nopt)
    end
    $display("test command table done");
    // Moving from one command straight to another must not fire the second one.
    host.access(1'b0, dcd_pkg::REG_CMD, 32'h00000008, q);
    host.access(1'b0, dcd_pkg::REG_CMD, 32'h00000009, q);
    host.access(1'b0, dcd_pkg::REG_CMD, 32'h00000000, q);
    host.access(1'b1, dcd_pkg::REG_PULSE, 32'h00000000, q);
    `CHK("pulse_once", 32'h00000020, q)
    host.access(1'b1, dcd_pkg::REG_PULSE, 32'h00000000, q);
    `CHK("pulse_clear", 32'h00000000, q)
    $display("test no zero between done");
    // A low clock enable must hold a pending command until it is raised, then fire it once.
    host.access(1'b0, dcd_pkg::REG_CMD, 32'h00000007, q);
    ce_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    `CHK("ce_hold", 6'h00, pulse)
    @(posedge clk_in);
    ce_in <= 1'b1;
    @(posedge clk_in);
    @(negedge clk_in);
    `CHK("ce_fire", 6'h38, pulse)
    @(negedge clk_in);
    `CHK("ce_once", 6'h00, pulse)
    host.access(1'b0, dcd_pkg::REG_CMD, 32'h00000000, q);
    host.access(1'b1, dcd_pkg::REG_PULSE, 32'h00000000, q);
    `CHK("ce_sticky", 32'h00000038, q)
    $display("test clock enable done");
    stop_test();
  end
endmodule
`default_nettype wire
